// ---- rtl/tsb_pkg.sv ----
// Constants shared by the channel interrupt enable bank and its leaf registers.
// Assumes a byte-addressed register port with 32-bit words on aligned offsets.
`default_nettype none

package tsb_pkg;

	// Port widths and channel count.
	localparam int unsigned ADDR_W = 12;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned NUM_CHAN = 64;

	// Register byte offsets.
	localparam logic [11:0] OFF_DONE_STS_LO = 12'h114;
	localparam logic [11:0] OFF_DONE_STS_HI = 12'h118;
	localparam logic [11:0] OFF_ERR_STS_LO = 12'h11C;
	localparam logic [11:0] OFF_ERR_STS_HI = 12'h120;
	localparam logic [11:0] OFF_DONE_ENA_LO = 12'h124;
	localparam logic [11:0] OFF_DONE_ENA_HI = 12'h128;
	localparam logic [11:0] OFF_ERR_ENA_LO = 12'h12C;
	localparam logic [11:0] OFF_ERR_ENA_HI = 12'h130;

	// Reset values and the value driven on idle or unmapped reads.
	localparam logic [31:0] RST_STS = 32'h0;
	localparam logic [31:0] RST_ENA = 32'h0;
	localparam logic [31:0] RDATA_IDLE = 32'h0;

	// True when a strobe addresses the given offset.
	function automatic logic reg_hit(input logic [11:0] addr, input logic [11:0] off,
			input logic stb);
		return stb && (addr == off);
	endfunction : reg_hit

endpackage : tsb_pkg

`default_nettype wire

// ---- rtl/tsb_w1c_bank.sv ----
// A word of sticky event flags, cleared by writing ones.
// Assumes set pulses come from logic on the same clock.
`default_nettype none

module tsb_w1c_bank #(
	parameter int unsigned W = 32
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [W-1:0] set_evt,
	input wire logic clr_wr,
	input wire logic [W-1:0] clr_data,
	output logic [W-1:0] sts
);

	typedef struct packed {
		logic [W-1:0] sts;
	} tsb_w1c_state_t;

	tsb_w1c_state_t st_q;
	tsb_w1c_state_t st_d;

	// A set in the same cycle as a clear wins, so no event is lost.
	always_comb begin
		st_d = st_q;
		if (clr_wr) begin
			st_d.sts = st_q.sts & ~clr_data;
		end
		st_d.sts = st_d.sts | set_evt;
	end

	// Flags come out of reset cleared.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			st_q.sts <= W'(tsb_pkg::RST_STS);
		end else begin
			st_q <= st_d;
		end
	end

	assign sts = st_q.sts;

endmodule : tsb_w1c_bank

`default_nettype wire

// ---- rtl/tsb_rw_bank.sv ----
// A plain read-write word, loaded whole on a write strobe.
// Assumes software does read-modify-write to change single bits.
`default_nettype none

module tsb_rw_bank #(
	parameter int unsigned W = 32
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic wr,
	input wire logic [W-1:0] wdata,
	output logic [W-1:0] q
);

	typedef struct packed {
		logic [W-1:0] val;
	} tsb_rw_state_t;

	tsb_rw_state_t st_q;
	tsb_rw_state_t st_d;

	// Load on a write, hold otherwise.
	always_comb begin
		st_d = st_q;
		if (wr) begin
			st_d.val = wdata;
		end
	end

	// Every enable comes out of reset masked.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			st_q.val <= W'(tsb_pkg::RST_ENA);
		end else begin
			st_q <= st_d;
		end
	end

	assign q = st_q.val;

endmodule : tsb_rw_bank

`default_nettype wire

// ---- rtl/tsb_chan_irq.sv ----
// Per-channel done and error interrupt flags, enables and combined interrupt.
// Assumes event pulses arrive from the stream unit on ref_clk, one cycle each.
//
// How it works
// - Upper channel error flags are sticky.
// - Writing one clears error flag; zero keeps.
// - Done enables for channels 0-31.
// - Done enables for channels 32-63.
// - Error enables for channels 0-31.
// - Enable one passes event, zero masks.
// - All enables reset to zero.
// - Each done enable written independently; here one write loads all 32 enables of its word at once.
// - Lower channel error flags sticky, write-one-clear.
// - Upper channel done flags sticky, write-one-clear.
//
// Our own choice: the strobed register port.
`default_nettype none

module tsb_chan_irq #(
	parameter int unsigned W = 32
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [11:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic [2*W-1:0] chan_done_evt,
	input wire logic [2*W-1:0] chan_err_evt,
	output logic irq
);

	typedef struct packed {
		logic [31:0] rdata;
	} tsb_top_state_t;

	tsb_top_state_t st_q;
	tsb_top_state_t st_d;

	logic [W-1:0] done_sts_lo;
	logic [W-1:0] done_sts_hi;
	logic [W-1:0] err_sts_lo;
	logic [W-1:0] err_sts_hi;
	logic [W-1:0] done_ena_lo;
	logic [W-1:0] done_ena_hi;
	logic [W-1:0] err_ena_lo;
	logic [W-1:0] err_ena_hi;
	logic wr_done_sts_lo;
	logic wr_done_sts_hi;
	logic wr_err_sts_lo;
	logic wr_err_sts_hi;
	logic wr_done_ena_lo;
	logic wr_done_ena_hi;
	logic wr_err_ena_lo;
	logic wr_err_ena_hi;

	// Write decode; one strobe selects at most one register.
	assign wr_done_sts_lo = tsb_pkg::reg_hit(reg_addr, tsb_pkg::OFF_DONE_STS_LO, reg_wr);
	assign wr_done_sts_hi = tsb_pkg::reg_hit(reg_addr, tsb_pkg::OFF_DONE_STS_HI, reg_wr);
	assign wr_err_sts_lo = tsb_pkg::reg_hit(reg_addr, tsb_pkg::OFF_ERR_STS_LO, reg_wr);
	assign wr_err_sts_hi = tsb_pkg::reg_hit(reg_addr, tsb_pkg::OFF_ERR_STS_HI, reg_wr);
	assign wr_done_ena_lo = tsb_pkg::reg_hit(reg_addr, tsb_pkg::OFF_DONE_ENA_LO, reg_wr);
	assign wr_done_ena_hi = tsb_pkg::reg_hit(reg_addr, tsb_pkg::OFF_DONE_ENA_HI, reg_wr);
	assign wr_err_ena_lo = tsb_pkg::reg_hit(reg_addr, tsb_pkg::OFF_ERR_ENA_LO, reg_wr);
	assign wr_err_ena_hi = tsb_pkg::reg_hit(reg_addr, tsb_pkg::OFF_ERR_ENA_HI, reg_wr);

	// Done flags of channels 0 to 31 share the same clear-by-one scheme.
	tsb_w1c_bank #(.W(W)) u_done_sts_lo (
		.ref_clk(ref_clk),
		.rst(rst),
		.set_evt(chan_done_evt[W-1:0]),
		.clr_wr(wr_done_sts_lo),
		.clr_data(reg_wdata[W-1:0]),
		.sts(done_sts_lo)
	);

	tsb_w1c_bank #(.W(W)) u_done_sts_hi (
		.ref_clk(ref_clk),
		.rst(rst),
		.set_evt(chan_done_evt[2*W-1:W]),
		.clr_wr(wr_done_sts_hi),
		.clr_data(reg_wdata[W-1:0]),
		.sts(done_sts_hi)
	);

	tsb_w1c_bank #(.W(W)) u_err_sts_lo (
		.ref_clk(ref_clk),
		.rst(rst),
		.set_evt(chan_err_evt[W-1:0]),
		.clr_wr(wr_err_sts_lo),
		.clr_data(reg_wdata[W-1:0]),
		.sts(err_sts_lo)
	);

	// write-one clears
	// Bit n of this word is channel n plus 32.
	tsb_w1c_bank #(.W(W)) u_err_sts_hi (
		.ref_clk(ref_clk),
		.rst(rst),
		.set_evt(chan_err_evt[2*W-1:W]),
		.clr_wr(wr_err_sts_hi),
		.clr_data(reg_wdata[W-1:0]),
		.sts(err_sts_hi)
	);

	tsb_rw_bank #(.W(W)) u_done_ena_lo (
		.ref_clk(ref_clk),
		.rst(rst),
		.wr(wr_done_ena_lo),
		.wdata(reg_wdata[W-1:0]),
		.q(done_ena_lo)
	);

	tsb_rw_bank #(.W(W)) u_done_ena_hi (
		.ref_clk(ref_clk),
		.rst(rst),
		.wr(wr_done_ena_hi),
		.wdata(reg_wdata[W-1:0]),
		.q(done_ena_hi)
	);

	tsb_rw_bank #(.W(W)) u_err_ena_lo (
		.ref_clk(ref_clk),
		.rst(rst),
		.wr(wr_err_ena_lo),
		.wdata(reg_wdata[W-1:0]),
		.q(err_ena_lo)
	);

	// Upper error enables; without them upper error flags could never interrupt.
	tsb_rw_bank #(.W(W)) u_err_ena_hi (
		.ref_clk(ref_clk),
		.rst(rst),
		.wr(wr_err_ena_hi),
		.wdata(reg_wdata[W-1:0]),
		.q(err_ena_hi)
	);

	// Read mux; data stand only in the cycle after the strobe, else zero.
	// Unmapped offsets read as zero so software probing gets a defined answer.
	always_comb begin
		st_d = st_q;
		st_d.rdata = tsb_pkg::RDATA_IDLE;
		if (reg_rd) begin
			case (reg_addr)
				tsb_pkg::OFF_DONE_STS_LO: st_d.rdata = 32'(done_sts_lo);
				tsb_pkg::OFF_DONE_STS_HI: st_d.rdata = 32'(done_sts_hi);
				tsb_pkg::OFF_ERR_STS_LO: st_d.rdata = 32'(err_sts_lo);
				tsb_pkg::OFF_ERR_STS_HI: st_d.rdata = 32'(err_sts_hi);
				tsb_pkg::OFF_DONE_ENA_LO: st_d.rdata = 32'(done_ena_lo);
				tsb_pkg::OFF_DONE_ENA_HI: st_d.rdata = 32'(done_ena_hi);
				tsb_pkg::OFF_ERR_ENA_LO: st_d.rdata = 32'(err_ena_lo);
				tsb_pkg::OFF_ERR_ENA_HI: st_d.rdata = 32'(err_ena_hi);
				default: st_d.rdata = tsb_pkg::RDATA_IDLE;
			endcase
		end
	end

	// Read data register.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			st_q.rdata <= tsb_pkg::RDATA_IDLE;
		end else begin
			st_q <= st_d;
		end
	end

	assign reg_rdata = st_q.rdata;

	// combined interrupt level
	// Built from registered flags and enables only, so it is glitch free.
	assign irq = |(done_sts_lo & done_ena_lo) | |(done_sts_hi & done_ena_hi)
		| |(err_sts_lo & err_ena_lo) | |(err_sts_hi & err_ena_hi);

	// Checks on the behaviour above.
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (rst);

	sequence s_wr_err_hi;
		wr_err_sts_hi && !(|chan_err_evt[2*W-1:W]);
	endsequence

	sequence s_wr_err_lo;
		wr_err_sts_lo && !(|chan_err_evt[W-1:0]);
	endsequence

	sequence s_wr_done_hi;
		wr_done_sts_hi && !(|chan_done_evt[2*W-1:W]);
	endsequence

	sequence s_no_clr_err_hi;
		!wr_err_sts_hi;
	endsequence

	logic rst_d1_q;

	// Remembers reset one cycle back, for the after-reset check.
	always_ff @(posedge ref_clk) begin
		rst_d1_q <= rst;
	end

	a_err_hi_sticky: assert property (
		s_no_clr_err_hi |=> ((err_sts_hi & $past(err_sts_hi)) == $past(err_sts_hi)))
		else $error("upper error flag dropped without a clear");

	a_err_hi_set: assert property (
		|chan_err_evt[2*W-1:W] |=>
		((err_sts_hi & $past(chan_err_evt[2*W-1:W])) == $past(chan_err_evt[2*W-1:W])))
		else $error("upper error event did not set its flag");

	a_rdata_err_hi: assert property (
		reg_rd && (reg_addr == tsb_pkg::OFF_ERR_STS_HI) |=>
		(reg_rdata == 32'($past(err_sts_hi))))
		else $error("upper error word read back wrong");

	a_err_hi_clear: assert property (
		s_wr_err_hi |=> ((err_sts_hi & $past(reg_wdata)) == 32'h0))
		else $error("write of one did not clear upper error flag");

	a_err_hi_keep: assert property (
		wr_err_sts_hi |=> (($past(err_sts_hi) & ~$past(reg_wdata) & ~err_sts_hi) == 32'h0))
		else $error("write of zero changed upper error flag");

	// flags leave reset cleared
	// Checked in the first cycle after release, before any event can land.
	a_rst_flags_clear: assert property (
		rst_d1_q |-> ((done_sts_lo | done_sts_hi | err_sts_lo | err_sts_hi) == 32'h0))
		else $error("status flags not cleared by reset");

	a_done_ena_lo: assert property (
		wr_done_ena_lo |=> (done_ena_lo == $past(reg_wdata)))
		else $error("lower done enable word not loaded");

	a_done_ena_lo_hold: assert property (
		!wr_done_ena_lo |=> $stable(done_ena_lo))
		else $error("lower done enable word changed without a write");

	// upper done enables load
	// A back-to-back write may legally change the word again, so it is let through.
	a_done_ena_hi: assert property (
		wr_done_ena_hi |=> (done_ena_hi == $past(reg_wdata))
		##1 ($stable(done_ena_hi) || $past(wr_done_ena_hi)) [*2])
		else $error("upper done enable word not loaded or not held");

	a_done_ena_hi_hold: assert property (
		!wr_done_ena_hi |=> $stable(done_ena_hi))
		else $error("upper done enable word changed without a write");

	a_err_ena_lo: assert property (
		wr_err_ena_lo ##1 !wr_err_ena_lo |=>
		(err_ena_lo == $past(reg_wdata, 2)) && $stable(err_ena_lo))
		else $error("lower error enable word not loaded");

	a_err_ena_lo_hold: assert property (
		!wr_err_ena_lo |=> $stable(err_ena_lo))
		else $error("lower error enable word changed without a write");

	a_irq_enabled: assert property (
		(|(chan_done_evt[W-1:0] & done_ena_lo)) && !wr_done_ena_lo |=> irq)
		else $error("enabled done event raised no interrupt");

	a_irq_err_hi: assert property (
		(|(chan_err_evt[2*W-1:W] & err_ena_hi)) && !wr_err_ena_hi |=> irq)
		else $error("enabled upper error event raised no interrupt");

	a_reset_masked: assert property (
		rst_d1_q |-> (done_ena_lo == 32'h0) && (done_ena_hi == 32'h0)
		&& (err_ena_lo == 32'h0) && (err_ena_hi == 32'h0) && !irq)
		else $error("enable bits not cleared by reset");

	a_ena_isolated: assert property (
		wr_done_ena_lo |=> $stable(done_ena_hi) && $stable(err_ena_lo) && $stable(err_ena_hi))
		else $error("done enable write disturbed another word");

	a_rdata_ena_lo: assert property (
		reg_rd && (reg_addr == tsb_pkg::OFF_DONE_ENA_LO) |=>
		(reg_rdata == 32'($past(done_ena_lo))))
		else $error("lower done enable word read back wrong");

	a_err_lo_clear: assert property (
		s_wr_err_lo |=> ((err_sts_lo & $past(reg_wdata)) == 32'h0))
		else $error("write of one did not clear lower error flag");

	a_err_lo_set: assert property (
		|chan_err_evt[W-1:0] |=>
		((err_sts_lo & $past(chan_err_evt[W-1:0])) == $past(chan_err_evt[W-1:0])))
		else $error("lower error event did not set its flag");

	a_err_lo_sticky: assert property (
		!wr_err_sts_lo |=> ((err_sts_lo & $past(err_sts_lo)) == $past(err_sts_lo)))
		else $error("lower error flag dropped without a clear");

	a_done_hi_read: assert property (
		s_wr_done_hi ##1 reg_rd && (reg_addr == tsb_pkg::OFF_DONE_STS_HI) |=>
		((reg_rdata & $past(reg_wdata, 2)) == 32'h0))
		else $error("cleared done flag still reads as set");

	a_done_hi_set: assert property (
		|chan_done_evt[2*W-1:W] |=>
		((done_sts_hi & $past(chan_done_evt[2*W-1:W])) == $past(chan_done_evt[2*W-1:W])))
		else $error("upper done event did not set its flag");

	a_done_hi_clear: assert property (
		s_wr_done_hi |=> ((done_sts_hi & $past(reg_wdata)) == 32'h0))
		else $error("write of one did not clear upper done flag");

	a_irq_masked: assert property (
		(done_ena_lo == 32'h0) && (done_ena_hi == 32'h0)
		&& (err_ena_lo == 32'h0) && (err_ena_hi == 32'h0) |-> !irq)
		else $error("interrupt raised with every enable clear");

	a_irq_cause: assert property (
		irq |-> (|(done_sts_lo | done_sts_hi | err_sts_lo | err_sts_hi)))
		else $error("interrupt high with no flag set");

	// Read data stand for one cycle only.
	a_rdata_idle: assert property (!reg_rd |=> (reg_rdata == 32'h0))
		else $error("read data present without a read");

endmodule : tsb_chan_irq

`default_nettype wire

// ---- verification/ts_channel_irq_enable_bank_tb_top.sv ----
// Self-checking bench for the channel interrupt flag and enable bank.
// Assumes the register port answers a read in the next cycle and irq follows flags at once.
`default_nettype none

module ts_channel_irq_enable_bank_tb_top;
	timeunit 1ns;
	timeprecision 1ns;

	logic ref_clk;
	logic rst;
	logic [11:0] reg_addr;
	logic [31:0] reg_wdata;
	logic reg_wr;
	logic reg_rd;
	logic [31:0] reg_rdata;
	logic [63:0] chan_done_evt;
	logic [63:0] chan_err_evt;
	logic irq;
	int fail_count;
	int checks;
	int cyc = 0;

	tsb_chan_irq #(.W(32)) u_dut (
		.ref_clk(ref_clk),
		.rst(rst),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.reg_rdata(reg_rdata),
		.chan_done_evt(chan_done_evt),
		.chan_err_evt(chan_err_evt),
		.irq(irq)
	);

	// A 100 ns clock; all bench drives land just after its rising edge.
	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end

	task automatic finish_test();
		$display("checks=%0d mismatches=%0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : finish_test

	// A hang is cut short at cycle 3000, long after the sequence could legitimately need it.
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			fail_count++;
			finish_test();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		#1;
	endtask : wr

	// Read data is taken only in the one cycle after the strobe.
	task automatic rd(input logic [11:0] a, input logic [31:0] exp);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1;
		chk(reg_rdata, exp);
	endtask : rd

	task automatic evt(input logic [63:0] done, input logic [63:0] err);
		@(posedge ref_clk);
		chan_done_evt <= done;
		chan_err_evt <= err;
		@(posedge ref_clk);
		chan_done_evt <= '0;
		chan_err_evt <= '0;
		#1;
	endtask : evt

	// Every word reads zero after reset, as does an unmapped place.
	task automatic t_reset();
		for (int i = 0; i < 8; i++) begin
			rd(12'h114 + 12'(4 * i), 32'h0);
		end
		rd(12'h200, 32'h0);
		chk({31'h0, irq}, 32'h0);
		$display("test reset done");
	endtask : t_reset

	// The done and lower error enable words keep what is written and do not disturb each other.
	task automatic t_enable();
		wr(tsb_pkg::OFF_DONE_ENA_LO, 32'hA5A5A5A5);
		wr(tsb_pkg::OFF_DONE_ENA_HI, 32'h5A5A5A5A);
		wr(tsb_pkg::OFF_ERR_ENA_LO, 32'hFFFF0000);
		rd(tsb_pkg::OFF_DONE_ENA_LO, 32'hA5A5A5A5);
		rd(tsb_pkg::OFF_DONE_ENA_HI, 32'h5A5A5A5A);
		rd(tsb_pkg::OFF_ERR_ENA_LO, 32'hFFFF0000);
		wr(tsb_pkg::OFF_DONE_ENA_LO, 32'hA5A5A5A4);
		rd(tsb_pkg::OFF_DONE_ENA_LO, 32'hA5A5A5A4);
		rd(tsb_pkg::OFF_DONE_ENA_HI, 32'h5A5A5A5A);
		wr(tsb_pkg::OFF_DONE_ENA_LO, 32'h0);
		wr(tsb_pkg::OFF_DONE_ENA_HI, 32'h0);
		wr(tsb_pkg::OFF_ERR_ENA_LO, 32'h0);
		$display("test enable done");
	endtask : t_enable

	// Upper error flags at both ends of the word, zero writes, one writes.
	task automatic t_err_hi();
		evt(64'h0, 64'h80000001_00000000);
		rd(tsb_pkg::OFF_ERR_STS_HI, 32'h80000001);
		chk({31'h0, irq}, 32'h0);
		wr(tsb_pkg::OFF_ERR_STS_HI, 32'h0);
		rd(tsb_pkg::OFF_ERR_STS_HI, 32'h80000001);
		wr(tsb_pkg::OFF_ERR_ENA_HI, 32'h1);
		chk({31'h0, irq}, 32'h1);
		wr(tsb_pkg::OFF_ERR_STS_HI, 32'h1);
		chk({31'h0, irq}, 32'h0);
		rd(tsb_pkg::OFF_ERR_STS_HI, 32'h80000000);
		wr(tsb_pkg::OFF_ERR_STS_HI, 32'h80000000);
		rd(tsb_pkg::OFF_ERR_STS_HI, 32'h0);
		wr(tsb_pkg::OFF_ERR_ENA_HI, 32'h0);
		$display("test upper error done");
	endtask : t_err_hi

	// The done and lower error enable words each gate only their own channels onto the interrupt.
	task automatic t_done();
		evt(64'h00000002_00000020, 64'h8);
		rd(tsb_pkg::OFF_DONE_STS_LO, 32'h20);
		rd(tsb_pkg::OFF_DONE_STS_HI, 32'h2);
		rd(tsb_pkg::OFF_ERR_STS_LO, 32'h8);
		chk({31'h0, irq}, 32'h0);
		wr(tsb_pkg::OFF_DONE_ENA_LO, 32'h20);
		chk({31'h0, irq}, 32'h1);
		wr(tsb_pkg::OFF_DONE_ENA_LO, 32'hFFFFFFDF);
		chk({31'h0, irq}, 32'h0);
		wr(tsb_pkg::OFF_DONE_ENA_HI, 32'h2);
		chk({31'h0, irq}, 32'h1);
		wr(tsb_pkg::OFF_DONE_STS_HI, 32'h2);
		chk({31'h0, irq}, 32'h0);
		wr(tsb_pkg::OFF_ERR_ENA_LO, 32'h8);
		chk({31'h0, irq}, 32'h1);
		wr(tsb_pkg::OFF_ERR_STS_LO, 32'h8);
		chk({31'h0, irq}, 32'h0);
		rd(tsb_pkg::OFF_ERR_STS_LO, 32'h0);
		rd(tsb_pkg::OFF_DONE_STS_HI, 32'h0);
		$display("test done and gating done");
	endtask : t_done

	// A mid-run reset must clear loaded enables; enabled events then interrupt at once.
	// The tail runs two writes and a read with no gap, which the other tasks never do.
	task automatic t_live();
		@(posedge ref_clk);
		rst <= 1'b1;
		repeat (2) @(posedge ref_clk);
		rst <= 1'b0;
		rd(tsb_pkg::OFF_DONE_ENA_LO, 32'h0);
		rd(tsb_pkg::OFF_DONE_ENA_HI, 32'h0);
		rd(tsb_pkg::OFF_ERR_ENA_LO, 32'h0);
		rd(tsb_pkg::OFF_DONE_STS_LO, 32'h0);
		wr(tsb_pkg::OFF_DONE_ENA_LO, 32'h1);
		wr(tsb_pkg::OFF_ERR_ENA_HI, 32'h100);
		evt(64'h00000003_00000001, 64'h00000100_00000000);
		chk({31'h0, irq}, 32'h1);
		wr(tsb_pkg::OFF_DONE_STS_LO, 32'h1);
		chk({31'h0, irq}, 32'h1);
		@(posedge ref_clk);
		reg_addr <= tsb_pkg::OFF_ERR_STS_HI;
		reg_wdata <= 32'h100;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_addr <= tsb_pkg::OFF_DONE_STS_HI;
		reg_wdata <= 32'h1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1;
		chk(reg_rdata, 32'h2);
		chk({31'h0, irq}, 32'h0);
		@(posedge ref_clk);
		#1;
		chk(reg_rdata, 32'h0);
		$display("test live done");
	endtask : t_live

	// Main sequence: six cycles of reset, then the scenarios in turn.
	initial begin
		fail_count = 0;
		checks = 0;
		rst = 1'b1;
		reg_addr = 12'h0;
		reg_wdata = 32'h0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		chan_done_evt = 64'h0;
		chan_err_evt = 64'h0;
		repeat (6) @(posedge ref_clk);
		rst <= 1'b0;
		t_reset();
		t_enable();
		t_err_hi();
		t_done();
		t_live();
		finish_test();
	end
endmodule : ts_channel_irq_enable_bank_tb_top

`default_nettype wire
